/* File: vcf_pkg.sv */
// shared constants for the video core control shell
package vcf_pkg;

    // register byte offsets
    localparam logic [7:0] CTRL_OFS      = 8'h00;
    localparam logic [7:0] STATUS_OFS    = 8'h04;
    localparam logic [7:0] ERROR_OFS     = 8'h08;
    localparam logic [7:0] SIZE_OFS      = 8'h20;

    // control register fields
    localparam int CTRL_EN_BIT   = 0;
    localparam int CTRL_SWRST_BIT = 1;

    // status register fields
    localparam int ST_STARTED_BIT = 0;
    localparam int ST_DONE_BIT    = 1;
    localparam int ST_ERR_BIT     = 16;

    // interrupt-source vector bit positions
    localparam int IV_START     = 0;
    localparam int IV_DONE      = 1;
    localparam int IV_PROTO     = 4;
    localparam int IV_LE_EARLY  = 5;
    localparam int IV_LE_LATE   = 6;
    localparam int IV_FS_EARLY  = 7;
    localparam int IV_FS_LATE   = 8;
    localparam int IV_WIDTH     = 9;

    // frame dimension field layout
    localparam int SIZE_PIX_LSB  = 0;
    localparam int SIZE_LINE_LSB = 16;
    localparam int DIM_W         = 13;
    localparam logic [31:0] SIZE_RST = 32'h0438_0780;

    // register access timeout, in control clock cycles
    localparam int TIMEOUT_CYC = 128;
    localparam int TMO_W       = 8;

    // response codes
    localparam logic [1:0] RESP_OKAY   = 2'b00;
    localparam logic [1:0] RESP_SLVERR = 2'b10;

    // reset stretcher length
    localparam int RST_HOLD_CYC = 32;

endpackage : vcf_pkg

/* File: vcf_req_if.sv */
// request/acknowledge bundle between the control and video domains
`timescale 1ns/100ps
`default_nettype none
interface vcf_req_if;
    logic        req_tgl;
    logic        ack_tgl;
    logic        wr;
    logic [7:0]  addr;
    logic [31:0] wdata;
    logic [31:0] rdata;
    modport ctl (output req_tgl, output wr, output addr, output wdata, input ack_tgl, input rdata);
    modport vid (input req_tgl, input wr, input addr, input wdata, output ack_tgl, output rdata);
endinterface : vcf_req_if
`default_nettype wire

/* File: vcf_sync.sv */
// two flop level synchroniser
`timescale 1ns/100ps
`default_nettype none
module vcf_sync #(
    parameter int WIDTH = 1
) (
    input  wire logic             i_clk,
    input  wire logic [WIDTH-1:0] i_d,
    output logic      [WIDTH-1:0] o_q
);
    logic [WIDTH-1:0] meta_q;

    always_ff @(posedge i_clk) begin
        meta_q <= i_d;
        o_q    <= meta_q;
    end
endmodule : vcf_sync
`default_nettype wire

/* File: vcf_top.sv */
// control shell: apb crossing, resets, enables, stream framing recovery
//
// Functional notes
// - vector bits: start, done, proto, framing errors
// - vector bits follow live events, unlatched
// - both stream ports on video clock only
// - register crossing times out with error on stalled video
// - video enable is plain, may tear frames
// - control enable gates register port only
// - video reset spares register port
// - control reset synchronised, resets everything
// - register access errors after 128 cycles
// - registers unreachable while video stalled
// - timed out access answers code 10
// - predict frame start, line end; flag errors
// - pixels bits 12:0, lines bits 28:16
// - early frame start ends output frame
// - late frame start: flag, drop surplus
// - early line end ends output line
// - late line end: emit, drop surplus
// - software reset through register port
// - bayer samples pass through unchanged arrangement
//
// Local design decisions: register access over APB and the placing of the registers.
`timescale 1ns/100ps
`default_nettype none
module vcf_top
    import vcf_pkg::*;
#(
    parameter int DATA_W = 16
) (
    input  wire logic              i_clk,
    input  wire logic              i_rst_n,
    input  wire logic              i_ctl_ce,
    input  wire logic              i_vclk,
    input  wire logic              i_vrst_n,
    input  wire logic              i_vce,
    input  wire logic              i_psel,
    input  wire logic              i_penable,
    input  wire logic              i_pwrite,
    input  wire logic [31:0]       i_paddr,
    input  wire logic [31:0]       i_pwdata,
    output logic      [31:0]       o_prdata,
    output logic                   o_pready,
    output logic                   o_pslverr,
    input  wire logic [DATA_W-1:0] i_s_tdata,
    input  wire logic              i_s_tvalid,
    input  wire logic              i_s_tuser,
    input  wire logic              i_s_tlast,
    output logic                   o_s_tready,
    output logic      [DATA_W-1:0] o_m_tdata,
    output logic                   o_m_tvalid,
    output logic                   o_m_tuser,
    output logic                   o_m_tlast,
    input  wire logic              i_m_tready,
    output logic      [IV_WIDTH-1:0] o_interrupt_source_vector
);
    if (DATA_W < 8 || DATA_W > 32) begin : g_bad_width
        $error("vcf_top: DATA_W out of range");
    end

    vcf_req_if xif ();

    // ---------------- control domain ----------------
    typedef enum logic [1:0] {C_IDLE = 2'b00, C_WAIT = 2'b01, C_DONE = 2'b11} vcf_cst_t;
    vcf_cst_t         cst_q;
    logic [TMO_W-1:0] tmo_q;
    logic             req_tgl_q;
    logic             wr_q;
    logic [7:0]       addr_q;
    logic [31:0]      wdata_q;
    logic             ack_s;
    logic             pend_q;
    logic [31:0]      rdata_s;

    assign xif.req_tgl = req_tgl_q;
    assign xif.wr      = wr_q;
    assign xif.addr    = addr_q;
    assign xif.wdata   = wdata_q;

    vcf_sync #(.WIDTH(1)) u_ack_sync (
        .i_clk (i_clk),
        .i_d   (xif.ack_tgl),
        .o_q   (ack_s)
    );
    // read data is held stable by the video side from the ack toggle until the next request
    assign rdata_s = xif.rdata;

    function automatic logic mapped(input logic [31:0] a);
        return a[31:8] == 24'h000000 &&
               (a[7:0] == CTRL_OFS || a[7:0] == STATUS_OFS || a[7:0] == ERROR_OFS || a[7:0] == SIZE_OFS);
    endfunction : mapped

    always_ff @(posedge i_clk) begin
        if (!i_rst_n) begin
            cst_q      <= C_IDLE;
            tmo_q      <= '0;
            req_tgl_q  <= 1'b0;
            wr_q       <= 1'b0;
            addr_q     <= 8'h00;
            wdata_q    <= 32'h0000_0000;
            pend_q     <= 1'b0;
            o_pready   <= 1'b0;
            o_pslverr  <= 1'b0;
            o_prdata   <= 32'h0000_0000;
        end else if (i_ctl_ce) begin
            o_pready  <= 1'b0;
            o_pslverr <= 1'b0;
            case (cst_q)
                C_IDLE: begin
                    if (i_psel && i_penable && !o_pready) begin
                        if (!mapped(i_paddr)) begin
                            o_pready  <= 1'b1;
                            o_pslverr <= 1'b1;
                            o_prdata  <= 32'h0000_0000;
                            cst_q     <= C_DONE;
                        end else begin
                            tmo_q     <= '0;
                            pend_q    <= 1'b1;
                            cst_q     <= C_WAIT;
                        end
                    end
                end
                C_WAIT: begin
                    if (ack_s == req_tgl_q && !pend_q) begin
                        o_pready   <= 1'b1;
                        o_prdata   <= wr_q ? 32'h0000_0000 : rdata_s;
                        cst_q      <= C_DONE;
                    end else if (tmo_q == TMO_W'(TIMEOUT_CYC - 1)) begin
                        o_pready  <= 1'b1;
                        o_pslverr <= 1'b1;
                        o_prdata  <= 32'h0000_0000;
                        cst_q     <= C_DONE;
                    end else begin
                        tmo_q <= tmo_q + TMO_W'(1);
                        // send only once an earlier timed-out access has drained
                        if (ack_s == req_tgl_q) begin
                            wr_q      <= i_pwrite;
                            addr_q    <= i_paddr[7:0];
                            wdata_q   <= i_pwdata;
                            req_tgl_q <= ~req_tgl_q;
                            pend_q    <= 1'b0;
                        end
                    end
                end
                C_DONE: begin
                    cst_q <= C_IDLE;
                end
                default: begin
                    cst_q <= C_IDLE;
                end
            endcase
        end
    end

    // ---------------- video domain resets ----------------
    logic       crst_s;
    logic       vrst_s;
    logic       ce_s;
    logic [5:0] hold_q;
    logic       vrst_q;
    logic       swrst_q;
    logic       en_q;
    logic       srst;

    vcf_sync #(.WIDTH(3)) u_rst_sync (
        .i_clk (i_vclk),
        .i_d   ({i_rst_n, i_vrst_n, i_vce}),
        .o_q   ({crst_s, vrst_s, ce_s})
    );

    always_ff @(posedge i_vclk) begin
        if (!crst_s || !vrst_s) begin
            hold_q <= 6'(RST_HOLD_CYC);
            vrst_q <= 1'b1;
        end else if (hold_q != 6'h00) begin
            hold_q <= hold_q - 6'h01;
            vrst_q <= 1'b1;
        end else begin
            vrst_q <= 1'b0;
        end
    end

    assign srst = vrst_q || swrst_q;

    // ---------------- video domain registers ----------------
    logic              req_s;
    logic              req_seen_q;
    logic              ack_tgl_q;
    logic [31:0]       rdata_q;
    logic [31:0]       size_q;
    logic [1:0]        stat_q;
    logic [3:0]        err_q;
    logic [3:0]        err_ev;
    logic [1:0]        stat_ev;
    logic              wr_hit;

    vcf_sync #(.WIDTH(1)) u_req_sync (
        .i_clk (i_vclk),
        .i_d   (xif.req_tgl),
        .o_q   (req_s)
    );
    assign xif.ack_tgl = ack_tgl_q;
    assign xif.rdata   = rdata_q;

    // registers served only when video enabled
    assign wr_hit = ce_s && vrst_s && (req_s != req_seen_q) && xif.wr;

    // register port not cleared by video reset
    always_ff @(posedge i_vclk) begin
        if (!crst_s) begin
            req_seen_q <= 1'b0;
            ack_tgl_q  <= 1'b0;
            rdata_q    <= 32'h0000_0000;
        end else if (ce_s && !vrst_s) begin
            req_seen_q <= req_seen_q;
        end else if (ce_s && req_s != req_seen_q) begin
            req_seen_q <= req_s;
            ack_tgl_q  <= ~ack_tgl_q;
            case (xif.addr)
                CTRL_OFS:   rdata_q <= {30'h0, swrst_q, en_q};
                STATUS_OFS: rdata_q <= {15'h0, |err_q, 14'h0, stat_q};
                ERROR_OFS:  rdata_q <= {28'h0, err_q};
                SIZE_OFS:   rdata_q <= size_q;
                default:    rdata_q <= 32'h0000_0000;
            endcase
        end
    end

    always_ff @(posedge i_vclk) begin
        if (!crst_s) begin
            en_q    <= 1'b0;
            swrst_q <= 1'b0;
            size_q  <= SIZE_RST;
        end else if (wr_hit && xif.addr == CTRL_OFS) begin
            en_q    <= xif.wdata[CTRL_EN_BIT];
            swrst_q <= xif.wdata[CTRL_SWRST_BIT];
        end else if (wr_hit && xif.addr == SIZE_OFS) begin
            size_q <= xif.wdata;
        end
    end

    // sticky flags, set wins over write-one clear
    always_ff @(posedge i_vclk) begin
        if (!crst_s || srst) begin
            stat_q <= 2'b00;
            err_q  <= 4'h0;
        end else begin
            stat_q <= stat_ev | (stat_q & ~((wr_hit && xif.addr == STATUS_OFS) ? xif.wdata[1:0] : 2'b00));
            err_q  <= err_ev  | (err_q  & ~((wr_hit && xif.addr == ERROR_OFS)  ? xif.wdata[3:0] : 4'h0));
        end
    end

    // ---------------- stream framing ----------------
    logic [DIM_W-1:0] pix_q;
    logic [DIM_W-1:0] line_q;
    logic [DIM_W-1:0] npix;
    logic [DIM_W-1:0] nline;
    logic             drop_q;
    logic             in_go;
    logic             out_free;
    logic             last_pix;
    logic             last_line;
    logic             act;

    assign npix      = size_q[SIZE_PIX_LSB +: DIM_W];
    assign nline     = size_q[SIZE_LINE_LSB +: DIM_W];
    assign last_pix  = pix_q == npix - DIM_W'(1);
    assign last_line = line_q == nline - DIM_W'(1);
    assign act       = ce_s && !srst && en_q;
    assign out_free  = !o_m_tvalid || i_m_tready;
    assign in_go     = act && i_s_tvalid && o_s_tready;

    always_ff @(posedge i_vclk) begin
        if (!crst_s || srst) begin
            o_s_tready <= 1'b0;
        end else begin
            // ready only if the output stage is empty next cycle, so no taken beat is lost
            o_s_tready <= act && !(o_m_tvalid && !i_m_tready) && !in_go;
        end
    end

    always_ff @(posedge i_vclk) begin
        if (!crst_s || srst) begin
            pix_q      <= '0;
            line_q     <= '0;
            drop_q     <= 1'b0;
            o_m_tvalid <= 1'b0;
            o_m_tdata  <= '0;
            o_m_tuser  <= 1'b0;
            o_m_tlast  <= 1'b0;
            stat_ev    <= 2'b00;
            err_ev     <= 4'h0;
        end else if (ce_s) begin
            stat_ev <= 2'b00;
            err_ev  <= 4'h0;
            if (i_m_tready) o_m_tvalid <= 1'b0;
            if (in_go && out_free) begin
                o_m_tdata <= i_s_tdata;
                if (i_s_tuser) begin
                    err_ev[2]  <= !(pix_q == '0 && line_q == '0) && !drop_q;
                    stat_ev[0] <= 1'b1;
                    drop_q     <= 1'b0;
                    o_m_tvalid <= 1'b1;
                    o_m_tuser  <= 1'b1;
                    o_m_tlast  <= i_s_tlast || npix == DIM_W'(1);
                    pix_q      <= DIM_W'(1);
                    line_q     <= '0;
                end else if (drop_q) begin
                    if (i_s_tlast && !(line_q == '0 && pix_q == '0)) drop_q <= 1'b0;
                end else if (line_q == '0 && pix_q == '0) begin
                    // late frame start flagged, surplus dropped
                    err_ev[3] <= 1'b1;
                    drop_q    <= 1'b1;
                end else begin
                    o_m_tvalid <= 1'b1;
                    o_m_tuser  <= 1'b0;
                    if (i_s_tlast || last_pix) begin
                        // line end at input or programmed spot
                        o_m_tlast  <= 1'b1;
                        err_ev[0]  <= i_s_tlast && !last_pix;
                        err_ev[1]  <= last_pix && !i_s_tlast;
                        drop_q     <= last_pix && !i_s_tlast && !last_line;
                        pix_q      <= '0;
                        line_q     <= last_line ? '0 : line_q + DIM_W'(1);
                        stat_ev[1] <= last_line;
                    end else begin
                        o_m_tlast <= 1'b0;
                        pix_q     <= pix_q + DIM_W'(1);
                    end
                end
            end
        end
    end

    always_ff @(posedge i_vclk) begin
        if (!crst_s) begin
            o_interrupt_source_vector <= '0;
        end else begin
            o_interrupt_source_vector              <= '0;
            o_interrupt_source_vector[IV_START]    <= stat_ev[0];
            o_interrupt_source_vector[IV_DONE]     <= stat_ev[1];
            o_interrupt_source_vector[IV_PROTO]    <= |err_ev;
            o_interrupt_source_vector[IV_LE_EARLY] <= err_ev[0];
            o_interrupt_source_vector[IV_LE_LATE]  <= err_ev[1];
            o_interrupt_source_vector[IV_FS_EARLY] <= err_ev[2];
            o_interrupt_source_vector[IV_FS_LATE]  <= err_ev[3];
        end
    end
endmodule : vcf_top
`default_nettype wire

/* File: vcf_sink_model.sv */
// downstream stream sink model that can stall and logs every beat
`timescale 1ns/100ps
`default_nettype none
module vcf_sink_model #(
    parameter int DATA_W = 16
) (
    input  wire logic              i_clk,
    input  wire logic              i_slow,
    input  wire logic [DATA_W-1:0] i_tdata,
    input  wire logic              i_tvalid,
    input  wire logic              i_tuser,
    input  wire logic              i_tlast,
    output logic                   o_tready
);
    logic [DATA_W+1:0] beats[$];
    logic              ph_q = 1'b0;
    // slow mode refuses every other cycle; the master must hold its beat
    always @(posedge i_clk) begin
        ph_q <= ~ph_q;
        if (i_tvalid && o_tready) begin
            beats.push_back({i_tuser, i_tlast, i_tdata});
        end
    end
    assign o_tready = !i_slow || ph_q;
endmodule : vcf_sink_model
`default_nettype wire

/* File: vcf_top_asserts.sv */
// port-level checks for the control shell
`timescale 1ns/100ps
`default_nettype none
module vcf_top_asserts
    import vcf_pkg::*;
#(
    parameter int DATA_W = 16
) (
    input wire logic                i_clk,
    input wire logic                i_rst_n,
    input wire logic                i_vclk,
    input wire logic                i_vrst_n,
    input wire logic                i_vce,
    input wire logic                i_psel,
    input wire logic                i_penable,
    input wire logic [31:0]         i_paddr,
    input wire logic                o_pready,
    input wire logic                o_pslverr,
    input wire logic                i_s_tvalid,
    input wire logic                i_s_tuser,
    input wire logic                o_s_tready,
    input wire logic [DATA_W-1:0]   o_m_tdata,
    input wire logic                o_m_tvalid,
    input wire logic                o_m_tuser,
    input wire logic                o_m_tlast,
    input wire logic                i_m_tready,
    input wire logic [IV_WIDTH-1:0] o_interrupt_source_vector
);
    logic [8:0]          wait_q;
    logic [IV_WIDTH-1:0] iv;
    logic                mapped;
    assign iv = o_interrupt_source_vector;
    assign mapped = i_paddr inside {CTRL_OFS, STATUS_OFS, ERROR_OFS, SIZE_OFS};
    // edges spent waiting in the current access phase
    always_ff @(posedge i_clk) begin
        wait_q <= (!i_rst_n || !(i_psel && i_penable) || o_pready) ? 9'h000 : wait_q + 9'h001;
    end
    a_iv_reserved: assert property (@(posedge i_vclk) disable iff (!i_vrst_n) iv[3:2] == 2'b00)
        else $error("reserved vector bits set");
    a_iv_summary: assert property (@(posedge i_vclk) disable iff (!i_vrst_n) iv[4] == |iv[8:5])
        else $error("framing summary bit mismatch");
    a_iv_unlatched: assert property (@(posedge i_vclk) disable iff (!i_vrst_n)
        |iv |=> (iv & $past(iv)) == '0) else $error("vector bit held");
    a_ready_pulse: assert property (@(posedge i_clk) disable iff (!i_rst_n) o_pready |=> !o_pready)
        else $error("pready longer than one cycle");
    a_err_with_ready: assert property (@(posedge i_clk) disable iff (!i_rst_n) o_pslverr |-> o_pready)
        else $error("pslverr without pready");
    a_wait_bound: assert property (@(posedge i_clk) disable iff (!i_rst_n)
        i_psel && i_penable |-> wait_q <= 9'd132) else $error("access not ended in time");
    a_tmo_not_early: assert property (@(posedge i_clk) disable iff (!i_rst_n)
        o_pready && o_pslverr && mapped |-> wait_q >= 9'd120) else $error("timeout error too early");
    a_ctl_rst_all: assert property (@(posedge i_vclk) disable iff (!i_vrst_n)
        (!i_rst_n) [*5] |-> !o_m_tvalid) else $error("control reset left stream active");
    a_out_hold: assert property (@(posedge i_vclk) disable iff (!i_vrst_n)
        o_m_tvalid && !i_m_tready |=> o_m_tvalid && $stable(o_m_tdata) && $stable(o_m_tlast))
        else $error("output beat changed while stalled");
    a_sof_follows: assert property (@(posedge i_vclk) disable iff (!i_vrst_n || !i_rst_n)
        i_s_tvalid && o_s_tready && i_s_tuser && i_m_tready && i_vce |=> o_m_tvalid && o_m_tuser)
        else $error("frame start not passed on");
endmodule : vcf_top_asserts
bind vcf_top vcf_top_asserts #(.DATA_W(DATA_W)) chk (.*);
`default_nettype wire

/* File: tb_vcf_top.sv */
// self-checking bench for the control shell
`timescale 1ns/100ps
`default_nettype none
module tb_vcf_top;
    import vcf_pkg::*;
    localparam int DATA_W = 16;
    logic i_clk = 0, i_rst_n = 0, i_ctl_ce = 1, i_vclk = 0, i_vrst_n = 0, i_vce = 1;
    logic i_psel = 0, i_penable = 0, i_pwrite = 0, i_s_tvalid = 0, i_s_tuser = 0, i_s_tlast = 0, slow = 0;
    logic [31:0] i_paddr = '0, i_pwdata = '0, o_prdata, rd;
    logic [DATA_W-1:0] i_s_tdata = '0, o_m_tdata;
    logic o_pready, o_pslverr, o_s_tready, o_m_tvalid, o_m_tuser, o_m_tlast, i_m_tready, err;
    logic [IV_WIDTH-1:0] o_interrupt_source_vector, seen;
    int n_errors = 0, n_compared = 0, cyc, n0;

    vcf_top #(.DATA_W(DATA_W)) uut (.*);
    vcf_sink_model #(.DATA_W(DATA_W)) sink (.i_clk(i_vclk), .i_slow(slow), .i_tdata(o_m_tdata),
        .i_tvalid(o_m_tvalid), .i_tuser(o_m_tuser), .i_tlast(o_m_tlast), .o_tready(i_m_tready));

    initial forever #2 i_clk = ~i_clk;
    initial begin
        #1;
        forever #3 i_vclk = ~i_vclk;
    end
    // vector bits captured as edge events
    always @(posedge i_vclk) seen <= seen | o_interrupt_source_vector;

    task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
        n_compared++;
        if (got !== exp) begin
            n_errors++;
            $display("wrong value %s expected %h seen %h", what, exp, got);
        end
    endtask : chk

    task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
        @(posedge i_clk);
        i_psel <= 1'b1;
        i_pwrite <= wr;
        i_paddr <= {24'h0, a};
        i_pwdata <= d;
        @(posedge i_clk);
        i_penable <= 1'b1;
        cyc = 0;
        do begin
            @(posedge i_clk);
            cyc++;
        end while (o_pready !== 1'b1 && cyc < 400);
        rd = o_prdata;
        err = o_pslverr;
        i_psel <= 1'b0;
        i_penable <= 1'b0;
        if (cyc >= 400) n_errors++;
    endtask : apb

    task automatic line(input int n, input logic sof);
        @(posedge i_vclk);
        for (int k = 0; k < n; k++) begin
            i_s_tvalid <= 1'b1;
            i_s_tdata <= DATA_W'(k);
            i_s_tuser <= sof && k == 0;
            i_s_tlast <= k == n - 1;
            do @(posedge i_vclk); while (o_s_tready !== 1'b1);
        end
        i_s_tvalid <= 1'b0;
        i_s_tdata <= 16'h5a5a;
    endtask : line

    // first line of `sent` pixels, then a full line; `kept` pixels of it survive
    task automatic frame(input int sent, input int kept);
        seen = '0;
        n0 = sink.beats.size();
        line(sent, 1'b1);
        line(8, 1'b0);
        repeat (30) @(posedge i_vclk);
        chk("beats", kept + 8, sink.beats.size() - n0);
        for (int k = 0; k < kept + 8; k++)
            chk("pixel", {k == 0, k == kept - 1 || k == kept + 7, DATA_W'(k < kept ? k : k - kept)}, sink.beats[n0 + k]);
    endtask : frame

    task automatic errs(input logic [4:0] v, input logic [31:0] e);
        chk("vector", v, seen[8:4]);
        apb(0, ERROR_OFS, 0);
        chk("error reg", e, rd);
        apb(1, ERROR_OFS, 32'hf);
        apb(0, ERROR_OFS, 0);
        chk("error clear", 0, rd);
    endtask : errs

    task automatic end_of_test;
        if (n_errors == 0 && n_compared > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask : end_of_test

    initial begin
        seen = '0;
        repeat (12) @(posedge i_clk);
        i_rst_n <= 1'b1;
        repeat (40) @(posedge i_vclk);
        i_vrst_n <= 1'b1;
        repeat (40) @(posedge i_vclk);
        apb(0, SIZE_OFS, 0);
        chk("size reset", SIZE_RST, rd);
        apb(0, 8'h40, 0);
        chk("unmapped err", 1, err);
        apb(1, SIZE_OFS, 32'h0002_0008);
        apb(0, SIZE_OFS, 0);
        chk("size", 32'h0002_0008, rd);
        apb(1, CTRL_OFS, 32'h1);
        slow <= 1'b1;
        frame(8, 8);
        chk("start done", 2'b11, seen[1:0]);
        slow <= 1'b0;
        errs(5'b00000, 0);
        frame(5, 5);
        errs(5'b00011, 32'h1);
        frame(10, 8);
        errs(5'b00101, 32'h2);
        seen = '0;
        line(8, 1'b1);
        repeat (30) @(posedge i_vclk);
        frame(8, 8);
        errs(5'b01001, 32'h4);
        i_ctl_ce <= 1'b0;
        frame(8, 8);
        i_ctl_ce <= 1'b1;
        apb(1, CTRL_OFS, 32'h3);
        apb(0, STATUS_OFS, 0);
        chk("soft reset status", 0, rd);
        apb(1, CTRL_OFS, 32'h1);
        @(posedge i_vclk);
        i_vrst_n <= 1'b0;
        apb(0, STATUS_OFS, 0);
        chk("timeout err", 1, err);
        chk("timeout time", 1, cyc >= 120 && cyc <= 135);
        @(posedge i_vclk);
        i_vrst_n <= 1'b1;
        repeat (80) @(posedge i_vclk);
        apb(0, SIZE_OFS, 0);
        chk("size kept", 32'h0002_0008, rd);
        @(posedge i_vclk);
        i_vce <= 1'b0;
        apb(0, SIZE_OFS, 0);
        chk("stalled err", 1, err);
        @(posedge i_vclk);
        i_vce <= 1'b1;
        @(posedge i_clk);
        i_rst_n <= 1'b0;
        repeat (12) @(posedge i_clk);
        i_rst_n <= 1'b1;
        repeat (40) @(posedge i_vclk);
        apb(0, SIZE_OFS, 0);
        chk("size after reset", SIZE_RST, rd);
        end_of_test();
    end

    initial begin
        repeat (20000) @(posedge i_clk);
        n_errors++;
        end_of_test();
    end
endmodule : tb_vcf_top
`default_nettype wire
